// ===== sms_pkg.sv
package sms_pkg;

    // ==========================================================================
    // Register map, one byte register per address.
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_TARGET = 3'h2;
    localparam logic [2:0] ADDR_TX = 3'h3;
    localparam logic [2:0] ADDR_RX = 3'h4;

    // ==========================================================================
    // Control field positions.
    localparam int CTL_MASTER_EN = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_START = 5;
    localparam int CTL_DIV_HI = 4;
    localparam int CTL_DIV_LO = 3;
    localparam int CTL_PHASE = 2;
    localparam int CTL_POLARITY = 1;
    localparam int CTL_RX_EDGE = 0;

    // Status field positions.
    localparam int STS_IRQ = 7;
    localparam int STS_TX_EMPTY = 3;
    localparam int STS_RX_FULL = 2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] HALF_DIV_BASE = 5'h02;
    localparam logic [3:0] BIT_LAST = 4'h8;

    typedef enum logic [2:0] {
        SMS_IDLE = 3'b000,
        SMS_SETUP = 3'b001,
        SMS_SHIFT = 3'b010,
        SMS_HOLD = 3'b011,
        SMS_GAP = 3'b100
    } sms_state_t;

    typedef struct packed {
        logic [7:0] sel_n;
        logic sck;
        logic mosi;
    } sms_spi_out_t;

    typedef struct packed {
        sms_state_t state;
        logic [7:0] control;
        logic [7:0] target;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic tx_empty;
        logic rx_full;
        logic irq_pend;
        logic [4:0] div_cnt;
        logic [3:0] edge_cnt;
        logic [3:0] bit_cnt;
        logic sck_lvl;
        logic sel_act;
        logic [7:0] rd_data;
        logic start_seen;
    } sms_regs_t;

endpackage : sms_pkg

// ===== sms_master.sv
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// Contract
// [RULE_01] With irq_enable set, IRQ output asserts while pending-interrupt flag is set.
// [RULE_02] Clearing irq_enable masks IRQ; pending flag stays as it was.
// [RULE_03] Start rising with tx_empty_flag low begins shifting the transmit byte; a rise written on the SMS_GAP tick starts nothing.
// [RULE_04] Every received byte is captured into receive_byte.
// [RULE_05] While start stays set, consecutive bytes keep being transferred.
// [RULE_06] Host clears start after last byte loaded and tx_empty_flag seen.
// [RULE_07] sck_divider 00,01,10,11 gives SCK of clock /4, /8, /16, /32.
// [RULE_08] clock_phase 0: data valid first edge; 1: valid second edge.
// [RULE_09] clock_polarity sets idle SCK: 0 low, 1 high.
// [RULE_10] rx_sample_edge 0 samples MISO on falling SCK, 1 on rising.
// [RULE_11] Host sets sample edge, phase and polarity to suit the slave.
// [RULE_12] Each set target_select bit asserts its select line during transfers.
// [RULE_13] Several set bits assert several select lines; nothing is enforced.
// [RULE_14] Host sets at most one target_select bit.
// [RULE_15] Written transmit byte goes out on MOSI while start is set.
// [RULE_16] Moving transmit byte into shift register sets tx_empty_flag.
// [RULE_17] Any write to transmit_byte clears tx_empty_flag; a write on the SMS_SETUP load tick does not, the flag is set.
// [RULE_18] No shifting starts unless tx_empty_flag low and start set together.
// [RULE_19] Completed received byte moved to receive_byte sets rx_full_flag.
// [RULE_20] Reading receive_byte clears rx_full_flag.
// [RULE_21] receive_byte is a holding register separate from the shift register.
// [RULE_22] master_enable low holds the master reset and disabled.
// [RULE_23] tx_empty_flag is status bit 3 and a pin; interrupts when start set.
// [RULE_24] rx_full_flag is status bit 2 and a pin; interrupts when start clear.
// [RULE_25] Bytes shift most significant bit first both directions.
// [RULE_26] Reset clears all registers: master disabled, no slave selected.
module sms_master
    import sms_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    output logic TX_EMPTY,
    output logic RX_FULL,
    output logic SCK,
    output logic MOSI,
    output logic [7:0] SEL_N,
    input wire logic MISO
);

    sms_regs_t r_ff;
    sms_regs_t nxt_r;
    sms_spi_out_t spi_ff;
    sms_spi_out_t nxt_spi;

    // ==========================================================================
    // Half-period of SCK in system clocks for a given divider code.
    function automatic logic [4:0] half_period(input logic [1:0] code);
        half_period = HALF_DIV_BASE << code; // [RULE_07]
    endfunction

    logic en;
    logic start;
    logic phase;
    logic pol;
    logic rx_edge;
    logic tick;
    logic sck_next;
    logic rising;

    assign en = r_ff.control[CTL_MASTER_EN];
    assign start = r_ff.control[CTL_START];
    assign phase = r_ff.control[CTL_PHASE];
    assign pol = r_ff.control[CTL_POLARITY];
    assign rx_edge = r_ff.control[CTL_RX_EDGE];

    // ==========================================================================
    // Next-state logic.
    always_comb begin
        nxt_r = r_ff;
        nxt_spi = spi_ff;
        tick = 1'b0;
        sck_next = r_ff.sck_lvl;
        rising = 1'b0;
        nxt_r.rd_data = RESET_BYTE;

        // Register writes.
        if (WR) begin
            case (ADDR)
                ADDR_CONTROL: begin
                    nxt_r.control = WDATA;
                    if (WDATA[CTL_START] && !r_ff.control[CTL_START]) begin
                        nxt_r.start_seen = 1'b1; // [RULE_03]
                    end
                end
                ADDR_TARGET: nxt_r.target = WDATA;
                ADDR_TX: begin
                    nxt_r.tx_byte = WDATA;
                    nxt_r.tx_empty = 1'b0; // [RULE_17]
                end
                ADDR_RX: nxt_r.rx_byte = WDATA;
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle.
        if (RD) begin
            case (ADDR)
                ADDR_CONTROL: nxt_r.rd_data = r_ff.control;
                ADDR_STATUS: begin
                    nxt_r.rd_data[STS_IRQ] = r_ff.irq_pend;
                    nxt_r.rd_data[STS_TX_EMPTY] = r_ff.tx_empty; // [RULE_23]
                    nxt_r.rd_data[STS_RX_FULL] = r_ff.rx_full; // [RULE_24]
                end
                ADDR_TARGET: nxt_r.rd_data = r_ff.target;
                ADDR_TX: nxt_r.rd_data = r_ff.tx_byte;
                ADDR_RX: begin
                    nxt_r.rd_data = r_ff.rx_byte;
                    nxt_r.rx_full = 1'b0; // [RULE_20]
                    nxt_r.irq_pend = 1'b0;
                end
                default: nxt_r.rd_data = RESET_BYTE;
            endcase
        end
        if (WR && ADDR == ADDR_TX) begin
            nxt_r.irq_pend = 1'b0;
        end

        // SCK divider: one tick per half period, freerunning while enabled.
        if (r_ff.div_cnt + 5'h01 >= half_period(r_ff.control[CTL_DIV_HI:CTL_DIV_LO])) begin
            nxt_r.div_cnt = 5'h00;
            tick = 1'b1;
        end else begin
            nxt_r.div_cnt = r_ff.div_cnt + 5'h01;
        end

        case (r_ff.state)
            SMS_IDLE: begin
                nxt_r.sck_lvl = pol; // [RULE_09]
                nxt_r.sel_act = 1'b0;
                // Level start alone is not enough after reset: a rising start or a running burst.
                if (tick && start && !r_ff.tx_empty && r_ff.start_seen) begin // [RULE_18]
                    nxt_r.state = SMS_SETUP;
                    nxt_r.sel_act = 1'b1;
                end
            end
            SMS_SETUP: begin
                // Select leads the first edge by two half periods.
                if (tick) begin
                    nxt_r.tx_shift = r_ff.tx_byte;
                    nxt_r.tx_empty = 1'b1; // [RULE_16]
                    if (start) begin
                        nxt_r.irq_pend = 1'b1; // [RULE_23]
                    end
                    nxt_r.edge_cnt = 4'h0;
                    nxt_r.bit_cnt = 4'h0;
                    nxt_r.state = SMS_SHIFT;
                    nxt_spi.mosi = r_ff.tx_byte[7]; // [RULE_25]
                end
            end
            SMS_SHIFT: begin
                if (tick) begin
                    sck_next = ~r_ff.sck_lvl;
                    nxt_r.sck_lvl = sck_next;
                    rising = sck_next;
                    nxt_r.edge_cnt = r_ff.edge_cnt + 4'h1;
                    // Phase 0 samples on odd edges, phase 1 shifts first then samples.
                    if (r_ff.edge_cnt[0] == phase) begin // [RULE_08]
                        nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
                    end else begin
                        nxt_r.tx_shift = {r_ff.tx_shift[6:0], 1'b0};
                        if (phase && r_ff.edge_cnt == 4'h0) begin
                            nxt_spi.mosi = r_ff.tx_shift[7]; // [RULE_15]
                        end else begin
                            nxt_spi.mosi = r_ff.tx_shift[6];
                        end
                        if (phase && r_ff.edge_cnt == 4'h0) begin
                            nxt_r.tx_shift = r_ff.tx_shift;
                        end
                    end
                    if (rising == rx_edge) begin // [RULE_10]
                        nxt_r.rx_shift = {r_ff.rx_shift[6:0], MISO}; // [RULE_25]
                    end
                    if (r_ff.edge_cnt == 4'hf) begin
                        nxt_r.rx_byte = {r_ff.rx_shift[6:0], MISO}; // [RULE_04] [RULE_21]
                        if (rising != rx_edge) begin
                            nxt_r.rx_byte = r_ff.rx_shift;
                        end
                        nxt_r.rx_full = 1'b1; // [RULE_19]
                        if (!start) begin
                            nxt_r.irq_pend = 1'b1; // [RULE_24]
                        end
                        nxt_r.state = SMS_HOLD;
                    end
                end
            end
            SMS_HOLD: begin
                nxt_r.sck_lvl = pol;
                if (tick) begin
                    // Phase 1 keeps select low across a continuing burst.
                    if (start && phase && !r_ff.tx_empty) begin // [RULE_05]
                        nxt_r.state = SMS_SETUP;
                    end else begin
                        nxt_r.state = SMS_GAP;
                        nxt_r.sel_act = 1'b0;
                    end
                end
            end
            SMS_GAP: begin
                if (tick) begin
                    nxt_r.state = SMS_IDLE;
                    nxt_r.start_seen = start; // [RULE_05]
                end
            end
            default: nxt_r.state = SMS_IDLE;
        endcase

        nxt_spi.sck = nxt_r.sck_lvl;
        nxt_spi.sel_n = ~(nxt_r.target & {8{nxt_r.sel_act}}); // [RULE_12] [RULE_13]

        // A disabled master holds its engine reset but keeps host-written settings.
        if (!en) begin // [RULE_22]
            nxt_r.state = SMS_IDLE;
            nxt_r.tx_empty = 1'b0;
            nxt_r.rx_full = 1'b0;
            nxt_r.irq_pend = 1'b0;
            nxt_r.div_cnt = 5'h00;
            nxt_r.sel_act = 1'b0;
            nxt_r.sck_lvl = nxt_r.control[CTL_POLARITY];
            // A write that enables the master and raises start together must still count as a start.
            nxt_r.start_seen = nxt_r.start_seen & nxt_r.control[CTL_MASTER_EN]; // [RULE_03]
            nxt_spi.sck = nxt_r.control[CTL_POLARITY];
            nxt_spi.mosi = 1'b0;
            nxt_spi.sel_n = 8'hff;
        end
    end

    // ==========================================================================
    // State register.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r_ff <= '0; // [RULE_26]
            spi_ff <= '{sel_n: 8'hff, sck: 1'b0, mosi: 1'b0};
        end else begin
            r_ff <= nxt_r;
            spi_ff <= nxt_spi;
        end
    end

    assign RDATA = r_ff.rd_data;
    assign IRQ = r_ff.irq_pend & r_ff.control[CTL_IRQ_EN]; // [RULE_01] [RULE_02]
    assign TX_EMPTY = r_ff.tx_empty; // [RULE_23]
    assign RX_FULL = r_ff.rx_full; // [RULE_24]
    assign SCK = spi_ff.sck;
    assign MOSI = spi_ff.mosi;
    assign SEL_N = spi_ff.sel_n;

endmodule // sms_master

// ===== sms_sva.sv
`timescale 1ns/10ps
// ========
// Pin checker; it keeps its own copy of control and target writes.
module sms_sva
    import sms_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic TX_EMPTY,
    input wire logic RX_FULL,
    input wire logic SCK,
    input wire logic MOSI,
    input wire logic [7:0] SEL_N,
    input wire logic MISO
);
    logic [7:0] ctl_ff, tgt_ff;
    logic [5:0] age_ff, run_ff, half;
    logic sck_ff, seen_ff;
    assign half = 6'h02 << ctl_ff[4:3];
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctl_ff <= 8'h00;
            tgt_ff <= 8'h00;
            age_ff <= 6'h00;
            run_ff <= 6'h00;
            sck_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            ctl_ff <= (WR && ADDR == ADDR_CONTROL) ? WDATA : ctl_ff;
            tgt_ff <= (WR && ADDR == ADDR_TARGET) ? WDATA : tgt_ff;
            age_ff <= (WR && ADDR == ADDR_CONTROL) ? 6'h00 : age_ff + {5'h00, age_ff != 6'h3f};
            run_ff <= (SCK != sck_ff) ? 6'h01 : run_ff + {5'h00, run_ff != 6'h3f};
            sck_ff <= SCK;
            seen_ff <= (SEL_N != 8'hff) && (seen_ff || SCK != sck_ff);
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    AST_TX_CLR: assert property (WR && ADDR == ADDR_TX |=> !TX_EMPTY)
        else $error("tx flag stayed set after a write");
    AST_RX_CLR: assert property (RD && ADDR == ADDR_RX |=> !RX_FULL)
        else $error("rx flag stayed set after a read");
    AST_IRQ_MASK: assert property (!ctl_ff[CTL_IRQ_EN] && age_ff > 6'h02 |-> !IRQ)
        else $error("interrupt while masked");
    AST_OFF: assert property (!ctl_ff[CTL_MASTER_EN] && age_ff > 6'h02 |-> SEL_N == 8'hff && !TX_EMPTY && !RX_FULL)
        else $error("activity while disabled");
    AST_IDLE_POL: assert property (ctl_ff[7] && age_ff == 6'h3f && SEL_N == 8'hff |-> SCK == ctl_ff[CTL_POLARITY])
        else $error("idle clock level wrong");
    AST_SEL_MASK: assert property ((~SEL_N & ~tgt_ff) == 8'h00)
        else $error("unselected line asserted");
    AST_SEL_ALL: assert property (SEL_N == 8'hff || ~SEL_N == tgt_ff)
        else $error("selected lines do not match target");
    AST_SCK_HALF: assert property (seen_ff && SCK != sck_ff && SEL_N != 8'hff |-> run_ff == half)
        else $error("clock half period wrong");
endmodule // sms_sva

bind sms_master sms_sva u_sva (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .TX_EMPTY(TX_EMPTY), .RX_FULL(RX_FULL), .SCK(SCK), .MOSI(MOSI), .SEL_N(SEL_N),
    .MISO(MISO));

// ===== sms_slave_model.sv
`timescale 1ns/10ps
// ========
// Slave peripheral: returns a reply byte and collects the byte sent to it.
module sms_slave_model (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial got = 8'h00;
    // Phase 0 needs the first bit on the line before the first edge.
    always @(negedge sel_n) begin
        sh = clock_phase ? reply : {reply[6:0], 1'b0};
        miso = reply[7];
    end
    always @(sck) begin
        if (!sel_n && sck == (clock_polarity ^ clock_phase)) begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end else if (!sel_n) begin
            got = {got[6:0], mosi};
        end
    end
    // A released line must not keep showing its last bit.
    always @(posedge sel_n) miso = ~miso;
endmodule // sms_slave_model

// ===== tb.sv
`timescale 1ns/10ps
// ========
module tb;
    import sms_pkg::*;
    logic CLK, SYS_RST, WR, RD, IRQ, TX_EMPTY, RX_FULL, SCK, MOSI, MISO, clock_polarity, clock_phase;
    logic [2:0] ADDR;
    logic [7:0] WDATA, RDATA, SEL_N, reply, v, got;
    int failures, samples_checked;
    logic [2:0] ts_r [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    sms_master DUT (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .IRQ(IRQ), .TX_EMPTY(TX_EMPTY), .RX_FULL(RX_FULL), .SCK(SCK), .MOSI(MOSI), .SEL_N(SEL_N), .MISO(MISO));
    sms_slave_model u_slave (.sck(SCK), .sel_n(&SEL_N), .mosi(MOSI), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .reply(reply),
        .miso(MISO), .got(got));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // Kinds: 0 tx empty, 1 rx full, 2 selected, 3 deselected.
    task automatic wait_flag(input int s);
        for (int k = 0; k < 3000; k++) begin
            @(posedge CLK);
            #1;
            if ((s == 0 && TX_EMPTY === 1'b1) || (s == 1 && RX_FULL === 1'b1) ||
                (s == 2 && SEL_N !== 8'hff) || (s == 3 && SEL_N === 8'hff)) return;
        end
        chk("wait", 8'(s), 8'hee);
    endtask
    task automatic t_modes;
        logic [7:0] ts [4] = '{8'h01, 8'h80, 8'h05, 8'h40};
        logic [7:0] ctl;
        for (int i = 0; i < 4; i++) begin
            clock_polarity = i[1];
            clock_phase = i[0];
            reply = 8'h3c + 8'(i);
            ctl = 8'h80 | 8'(i << 3) | {5'h00, i[0], i[1], i[0] == i[1]};
            wr(ADDR_TARGET, ts[i]);
            wr(ADDR_TX, 8'hc5 ^ 8'(i));
            wr(ADDR_CONTROL, ctl);
            repeat (70) @(posedge CLK);
            chk("idle sck", {7'h00, clock_polarity}, SCK);
            wr(ADDR_CONTROL, ctl | 8'h20);
            wait_flag(2);
            chk("selects", ~ts[i], SEL_N);
            wait_flag(0);
            wr(ADDR_CONTROL, ctl);
            wait_flag(1);
            rd(ADDR_RX, v);
            chk("received", 8'h3c + 8'(i), v);
            chk("sent", 8'hc5 ^ 8'(i), got);
            chk("rx flag", 8'h00, RX_FULL);
            wait_flag(3);
        end
    endtask
    task automatic t_burst;
        clock_polarity = 1'b0;
        clock_phase = 1'b0;
        reply = 8'h99;
        wr(ADDR_TARGET, 8'h01);
        wr(ADDR_TX, 8'h11);
        wr(ADDR_CONTROL, 8'hc1);
        wr(ADDR_CONTROL, 8'he1);
        wait_flag(0);
        repeat (2) @(posedge CLK);
        chk("irq tx", 8'h01, IRQ);
        wr(ADDR_TX, 8'h22);
        chk("tx flag", 8'h00, TX_EMPTY);
        wait_flag(1);
        rd(ADDR_RX, v);
        chk("first byte", 8'h99, v);
        wait_flag(0);
        wr(ADDR_CONTROL, 8'hc1);
        wait_flag(1);
        repeat (2) @(posedge CLK);
        chk("irq rx", 8'h01, IRQ);
        chk("second sent", 8'h22, got);
        wr(ADDR_CONTROL, 8'h81);
        repeat (2) @(posedge CLK);
        chk("irq off", 8'h00, IRQ);
        rd(ADDR_STATUS, v);
        chk("status", 8'h8c, v);
    endtask
    task automatic t_refuse;
        wr(ADDR_CONTROL, 8'ha1);
        for (int k = 0; k < 200 && SEL_N === 8'hff; k++) @(posedge CLK);
        chk("no start", 8'hff, SEL_N);
        wr(ADDR_CONTROL, 8'h21);
        wr(ADDR_TX, 8'h5a);
        wr(ADDR_STATUS, 8'hff);
        repeat (100) @(posedge CLK);
        chk("off selects", 8'hff, SEL_N);
        rd(ADDR_CONTROL, v);
        chk("control", 8'h21, v);
        rd(ADDR_STATUS, v);
        chk("off status", 8'h00, v);
    endtask
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {WR, RD, ADDR, WDATA, clock_polarity, clock_phase, reply} = '0;
        failures = 0;
        samples_checked = 0;
        SYS_RST = 1'b1;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        foreach (ts_r[i]) begin
            rd(ts_r[i], v);
            chk("reset read", 8'h00, v);
        end
        t_modes();
        t_burst();
        t_refuse();
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge CLK);
        failures++;
        print_verdict();
    end
endmodule // tb
